// [hdl/slk_defines.svh]
// Constants for the safety link state and diagnostic reporter
`ifndef SLK_DEFINES_SVH
`define SLK_DEFINES_SVH

// Connection state codes
`define SLK_ST_RESET 8'h64
`define SLK_ST_SESSION 8'h65
`define SLK_ST_CONN 8'h66
`define SLK_ST_PARAM 8'h67
`define SLK_ST_DATA 8'h68
`define SLK_ST_SHUT 8'h69
`define SLK_ST_SHUTDEACT 8'h6a

// Diagnostic byte: cause codes in the low nibble, flags above
`define SLK_DC_NONE 4'h0
`define SLK_DC_INV_CMD 4'h1
`define SLK_DC_UNK_CMD 4'h2
`define SLK_DC_INV_CONNID 4'h3
`define SLK_DC_BAD_CRC 4'h4
`define SLK_DC_WATCHDOG 4'h5
`define SLK_DC_INV_ADDR 4'h6
`define SLK_DC_INV_DATA 4'h7
`define SLK_DC_COMPRM_LEN 4'h8
`define SLK_DC_COMPRM 4'h9
`define SLK_DC_USRPRM_LEN 4'ha
`define SLK_DC_USRPRM 4'hb
`define SLK_DC_MST_RESET 4'hc
`define SLK_DC_MODFLT_LINK 4'hd
`define SLK_DC_MODFLT_OUT 4'he
`define SLK_DC_NOT_STARTED 4'hf
`define SLK_DB_SLV_ERR 4
`define SLK_DB_SLV_FS 5
`define SLK_DB_STARTUP 6
`define SLK_DB_MST_FS 7
`define SLK_DIAG_RST 8'h40

// Register byte offsets
`define SLK_REG_CTRL 8'h00
`define SLK_REG_STATUS 8'h04
`define SLK_REG_IRQ_STAT 8'h08
`define SLK_REG_IRQ_MASK 8'h0c
`define SLK_REG_SAFE_OUT 8'h10
`define SLK_REG_PIMG_DIAG 8'h14
`define SLK_REG_PIMG_IO 8'h18

// Control register fields
`define SLK_CB_ACTIVATE 0
`define SLK_CB_DEACTIVATE 1
`define SLK_CB_MST_RESET 2
`define SLK_CB_MODFLT_LINK 3
`define SLK_CB_ERRACK 4
`define SLK_CB_OUT_SLAVE 5
`define SLK_CB_MAP_STATE 6
`define SLK_CB_MAP_DIAG 7
`define SLK_CB_MAP_IN 8
`define SLK_CB_MAP_OUT 9
`define SLK_CTRL_W 10

// Interrupt status fields
`define SLK_IB_FAULT 0
`define SLK_IB_DATA 1
`define SLK_IB_SHUT 2
`define SLK_IRQ_W 3

// Watchdog
`define SLK_CLK_MHZ 10
`define SLK_WD_TIME_MS 100
`define SLK_WD_CYCLES (`SLK_WD_TIME_MS * 1000 * `SLK_CLK_MHZ)

`endif

// [hdl/slk_link_if.sv]
// Link between the safety master controller and the remote safety slave
interface slk_link_if;
  import slk_pkg::*;
  logic mstValid;
  logic [2:0] mstCmd;
  logic [7:0] mstAddr;
  logic [15:0] mstData;
  logic [7:0] mstChk;
  logic slvValid;
  logic [2:0] slvCmd;
  logic [7:0] slvAddr;
  logic [15:0] slvData;
  logic [7:0] slvChk;
  logic [3:0] slvCode;
  logic slvErr;
  logic slvFailsafe;
  logic slvModFault;

  modport master (
    output mstValid, mstCmd, mstAddr, mstData, mstChk,
    input slvValid, slvCmd, slvAddr, slvData, slvChk, slvCode,
    input slvErr, slvFailsafe, slvModFault
  );
  modport slave (
    input mstValid, mstCmd, mstAddr, mstData, mstChk,
    output slvValid, slvCmd, slvAddr, slvData, slvChk, slvCode,
    output slvErr, slvFailsafe, slvModFault
  );
endinterface : slk_link_if

// [hdl/slk_master.sv]
// Safety master end: connection phase, state code and diagnostic byte
`include "slk_defines.svh"
// Contract
// - Keep diagnostic byte beside state code
// - Low nibble codes 1-7: frame faults
// - Low nibble codes 8-12: parameter, master reset
// - Code 13: module fault as link fault
// - Code 14 output module fault; 15 not started
// - Bit 4 slave error, bit 6 startup
// - Bit 5 slave applies failsafe values
// - Bit 7 master applies failsafe values
// - State 100 in reset phase
// - Session phase 101 exchanges session ids
// - Connection phase 102 sends connection id
// - Parameter phase 103 transfers parameters
// - Data phase 104 cycles until error/stop
// - State 105 after shutdown by partner
// - State 106 after shutdown by deactivate
// - Map state, diagnostics into process image
// - Map safe inputs and outputs too
module slk_master
  import slk_pkg::*;
#(
  parameter int WD_CYCLES = `SLK_WD_CYCLES,
  parameter logic [7:0] SLAVE_ADDR = 8'h01,
  parameter logic [15:0] CONN_ID = 16'h0001,
  parameter logic [15:0] PRM_WORD = 16'h0204
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  slk_link_if.master link,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic irq
);
  slk_phase_t phase_q, phase_d;
  logic waitRsp_q, waitRsp_d;
  logic [31:0] wdCnt_q, wdCnt_d;
  logic [3:0] code_q, code_d;
  logic slvErr_q, slvErr_d;
  logic slvFs_q, slvFs_d;
  logic mstFs_q, mstFs_d;
  logic [15:0] safeIn_q, safeIn_d;
  logic txValid_q, txValid_d;
  logic [2:0] txCmd_q, txCmd_d;
  logic [15:0] txData_q, txData_d;
  logic [`SLK_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [15:0] safeOut_q, safeOut_d;
  logic [`SLK_IRQ_W-1:0] irqStat_q, irqStat_d;
  logic [`SLK_IRQ_W-1:0] irqMask_q, irqMask_d;
  logic [15:0] pimgDiag_q, pimgDiag_d;
  logic [31:0] pimgIo_q, pimgIo_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] stateCode;
  logic [7:0] diag;
  logic [2:0] expCmd;
  logic fault;
  logic [3:0] faultCode;
  logic [`SLK_IRQ_W-1:0] evt;

  always_comb
  begin
    case (phase_q)
      SLK_PH_RESET: stateCode = `SLK_ST_RESET;
      SLK_PH_SESSION: stateCode = `SLK_ST_SESSION;
      SLK_PH_CONN: stateCode = `SLK_ST_CONN;
      SLK_PH_PARAM: stateCode = `SLK_ST_PARAM;
      SLK_PH_DATA: stateCode = `SLK_ST_DATA;
      SLK_PH_SHUT: stateCode = `SLK_ST_SHUT;
      SLK_PH_SHUTDEACT: stateCode = `SLK_ST_SHUTDEACT;
      default: stateCode = `SLK_ST_RESET;
    endcase
    case (phase_q)
      SLK_PH_SESSION: expCmd = SLK_CMD_SESSION;
      SLK_PH_CONN: expCmd = SLK_CMD_CONN;
      SLK_PH_PARAM: expCmd = SLK_CMD_PARAM;
      SLK_PH_DATA: expCmd = SLK_CMD_DATA;
      default: expCmd = SLK_CMD_RESET;
    endcase
  end

  // Diagnostic byte assembled from registered flags, the phase and the latched cause
  always_comb
  begin
    diag = {4'h0, code_q};
    diag[`SLK_DB_SLV_ERR] = slvErr_q;
    diag[`SLK_DB_SLV_FS] = slvFs_q;
    diag[`SLK_DB_STARTUP] = (phase_q != SLK_PH_DATA);
    diag[`SLK_DB_MST_FS] = mstFs_q;
  end

  // Protocol sequencing
  always_comb
  begin
    phase_d = phase_q;
    waitRsp_d = waitRsp_q;
    wdCnt_d = wdCnt_q;
    code_d = code_q;
    slvErr_d = slvErr_q;
    slvFs_d = slvFs_q;
    mstFs_d = mstFs_q;
    safeIn_d = safeIn_q;
    txValid_d = 1'b0;
    txCmd_d = txCmd_q;
    txData_d = txData_q;
    fault = 1'b0;
    faultCode = `SLK_DC_NONE;
    if (waitRsp_q && !link.slvValid)
    begin
      wdCnt_d = wdCnt_q + 32'h1;
      if (wdCnt_q >= WD_CYCLES - 1)
      begin
        fault = 1'b1;
        faultCode = `SLK_DC_WATCHDOG;
      end
    end
    if (waitRsp_q && link.slvValid)
    begin
      waitRsp_d = 1'b0;
      slvErr_d = link.slvErr;
      slvFs_d = link.slvFailsafe;
      fault = 1'b1;
      if (link.slvChk != slk_chk(link.slvCmd, link.slvAddr, link.slvData))
        faultCode = `SLK_DC_BAD_CRC;
      else if (link.slvAddr != SLAVE_ADDR)
        faultCode = `SLK_DC_INV_ADDR;
      else if (link.slvCmd == SLK_CMD_NONE || link.slvCmd == SLK_CMD_BAD)
        faultCode = `SLK_DC_UNK_CMD;
      else if (link.slvCmd == SLK_CMD_RESET && link.slvCode != 4'h0)
        faultCode = link.slvCode;
      else if (link.slvCmd == SLK_CMD_SHUTDOWN)
      begin
        fault = 1'b0;
        phase_d = SLK_PH_SHUT;
        mstFs_d = 1'b1;
      end
      else if (link.slvCmd != expCmd)
        faultCode = `SLK_DC_INV_CMD;
      else if (phase_q == SLK_PH_DATA && link.slvModFault &&
               ctrl_q[`SLK_CB_MODFLT_LINK])
        faultCode = `SLK_DC_MODFLT_LINK;
      else if (phase_q == SLK_PH_DATA && link.slvModFault &&
               ctrl_q[`SLK_CB_ERRACK] && ctrl_q[`SLK_CB_OUT_SLAVE])
        faultCode = `SLK_DC_MODFLT_OUT;
      else if (phase_q == SLK_PH_SESSION && link.slvData == 16'h0000)
        faultCode = `SLK_DC_INV_DATA;
      else if (phase_q == SLK_PH_CONN && link.slvData != CONN_ID)
        faultCode = `SLK_DC_INV_CONNID;
      else
      begin
        fault = 1'b0;
        case (phase_q)
          SLK_PH_RESET: phase_d = SLK_PH_SESSION;
          SLK_PH_SESSION: phase_d = SLK_PH_CONN;
          SLK_PH_CONN: phase_d = SLK_PH_PARAM;
          SLK_PH_PARAM:
          begin
            phase_d = SLK_PH_DATA;
            code_d = `SLK_DC_NONE;
            mstFs_d = 1'b0;
          end
          SLK_PH_DATA: safeIn_d = link.slvData;
          default: phase_d = phase_q;
        endcase
      end
    end
    // Send the next frame once the previous answer is in
    if (!waitRsp_d && !fault && !txValid_q &&
        (phase_d == SLK_PH_RESET ? ctrl_q[`SLK_CB_ACTIVATE] :
         (phase_d != SLK_PH_SHUT && phase_d != SLK_PH_SHUTDEACT)))
    begin
      txValid_d = 1'b1;
      waitRsp_d = 1'b1;
      wdCnt_d = 32'h0;
      case (phase_d)
        SLK_PH_SESSION:
        begin
          txCmd_d = SLK_CMD_SESSION;
          txData_d = wdCnt_q[15:0] | 16'h0001;
        end
        SLK_PH_CONN:
        begin
          txCmd_d = SLK_CMD_CONN;
          txData_d = CONN_ID;
        end
        SLK_PH_PARAM:
        begin
          txCmd_d = SLK_CMD_PARAM;
          txData_d = PRM_WORD;
        end
        SLK_PH_DATA:
        begin
          txCmd_d = SLK_CMD_DATA;
          txData_d = safeOut_q;
        end
        default:
        begin
          txCmd_d = SLK_CMD_RESET;
          txData_d = 16'h0000;
        end
      endcase
    end
    // Software reset takes priority over link events
    if (ctrl_q[`SLK_CB_MST_RESET])
    begin
      fault = 1'b1;
      faultCode = `SLK_DC_MST_RESET;
    end
    if (fault)
    begin
      phase_d = SLK_PH_RESET;
      code_d = faultCode;
      mstFs_d = 1'b1;
      waitRsp_d = 1'b0;
      txValid_d = 1'b0;
    end
    if (ctrl_q[`SLK_CB_DEACTIVATE])
    begin
      phase_d = SLK_PH_SHUTDEACT;
      mstFs_d = 1'b1;
      waitRsp_d = 1'b0;
      txValid_d = 1'b0;
    end
    else if (phase_q == SLK_PH_SHUTDEACT)
      phase_d = SLK_PH_RESET;
  end

  assign evt[`SLK_IB_FAULT] = fault;
  assign evt[`SLK_IB_DATA] = (phase_d == SLK_PH_DATA) &&
                             (phase_q != SLK_PH_DATA);
  assign evt[`SLK_IB_SHUT] = (phase_d == SLK_PH_SHUT ||
                              phase_d == SLK_PH_SHUTDEACT) &&
                             phase_d != phase_q;

  // Register port and process image
  always_comb
  begin
    ctrl_d = ctrl_q;
    ctrl_d[`SLK_CB_MST_RESET] = 1'b0;
    safeOut_d = safeOut_q;
    irqMask_d = irqMask_q;
    irqStat_d = irqStat_q;
    rdata_d = 32'h0;
    if (regWr)
    begin
      case (regAddr)
        `SLK_REG_CTRL: ctrl_d = regWdata[`SLK_CTRL_W-1:0];
        `SLK_REG_IRQ_MASK: irqMask_d = regWdata[`SLK_IRQ_W-1:0];
        `SLK_REG_SAFE_OUT: safeOut_d = regWdata[15:0];
        default: ctrl_d = ctrl_d;
      endcase
    end
    if (regRd)
    begin
      case (regAddr)
        `SLK_REG_CTRL: rdata_d = {22'h0, ctrl_q};
        `SLK_REG_STATUS: rdata_d = {16'h0, diag, stateCode};
        `SLK_REG_IRQ_STAT:
        begin
          rdata_d = {29'h0, irqStat_q};
          irqStat_d = '0;
        end
        `SLK_REG_IRQ_MASK: rdata_d = {29'h0, irqMask_q};
        `SLK_REG_SAFE_OUT: rdata_d = {16'h0, safeOut_q};
        `SLK_REG_PIMG_DIAG: rdata_d = {16'h0, pimgDiag_q};
        `SLK_REG_PIMG_IO: rdata_d = pimgIo_q;
        default: rdata_d = 32'h0;
      endcase
    end
    // New events win over the clearing read
    irqStat_d = irqStat_d | evt;
    pimgDiag_d[7:0] = ctrl_q[`SLK_CB_MAP_STATE] ? stateCode : 8'h00;
    pimgDiag_d[15:8] = ctrl_q[`SLK_CB_MAP_DIAG] ? diag : 8'h00;
    pimgIo_d[15:0] = ctrl_q[`SLK_CB_MAP_IN] ? safeIn_q : 16'h0000;
    pimgIo_d[31:16] = ctrl_q[`SLK_CB_MAP_OUT] ? safeOut_q : 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= SLK_PH_RESET;
      waitRsp_q <= 1'b0;
      wdCnt_q <= 32'h0;
      code_q <= `SLK_DC_NONE;
      slvErr_q <= 1'b0;
      slvFs_q <= 1'b0;
      mstFs_q <= 1'b0;
      safeIn_q <= 16'h0000;
      txValid_q <= 1'b0;
      txCmd_q <= SLK_CMD_NONE;
      txData_q <= 16'h0000;
      ctrl_q <= '0;
      safeOut_q <= 16'h0000;
      irqStat_q <= '0;
      irqMask_q <= '0;
      pimgDiag_q <= 16'h0000;
      pimgIo_q <= 32'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      phase_q <= phase_d;
      waitRsp_q <= waitRsp_d;
      wdCnt_q <= wdCnt_d;
      code_q <= code_d;
      slvErr_q <= slvErr_d;
      slvFs_q <= slvFs_d;
      mstFs_q <= mstFs_d;
      safeIn_q <= safeIn_d;
      txValid_q <= txValid_d;
      txCmd_q <= txCmd_d;
      txData_q <= txData_d;
      ctrl_q <= ctrl_d;
      safeOut_q <= safeOut_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      pimgDiag_q <= pimgDiag_d;
      pimgIo_q <= pimgIo_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.mstValid = txValid_q;
  assign link.mstCmd = txCmd_q;
  assign link.mstAddr = SLAVE_ADDR;
  assign link.mstData = txData_q;
  assign link.mstChk = slk_chk(txCmd_q, SLAVE_ADDR, txData_q);
  assign regRdata = rdata_q;
  assign irq = |(irqStat_q & irqMask_q);
endmodule : slk_master

// [hdl/slk_pkg.sv]
// Types shared by both ends of the safety link
package slk_pkg;
  typedef enum logic [2:0] {
    SLK_CMD_NONE = 3'h0,
    SLK_CMD_RESET = 3'h1,
    SLK_CMD_SESSION = 3'h2,
    SLK_CMD_CONN = 3'h3,
    SLK_CMD_PARAM = 3'h4,
    SLK_CMD_DATA = 3'h5,
    SLK_CMD_SHUTDOWN = 3'h6,
    SLK_CMD_BAD = 3'h7
  } slk_cmd_t;

  typedef enum logic [6:0] {
    SLK_PH_RESET = 7'h01,
    SLK_PH_SESSION = 7'h02,
    SLK_PH_CONN = 7'h04,
    SLK_PH_PARAM = 7'h08,
    SLK_PH_DATA = 7'h10,
    SLK_PH_SHUT = 7'h20,
    SLK_PH_SHUTDEACT = 7'h40
  } slk_phase_t;

  // Frame check over command, address and payload
  function automatic logic [7:0] slk_chk(
    input logic [2:0] cmd,
    input logic [7:0] addr,
    input logic [15:0] data
  );
    slk_chk = data[15:8] ^ data[7:0] ^ addr ^ {5'h00, cmd};
  endfunction : slk_chk
endpackage : slk_pkg

// [hdl/slk_slave.sv]
// Remote safety slave end of the link
`include "slk_defines.svh"
module slk_slave
  import slk_pkg::*;
#(
  parameter logic [7:0] NODE_ADDR = 8'h01,
  parameter logic [7:0] COMM_PRM_LEN = 8'h02,
  parameter logic [7:0] USER_PRM_LEN = 8'h04
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  slk_link_if.slave link,
  input wire logic started,
  input wire logic moduleFault,
  input wire logic failsafeActive,
  input wire logic shutdownReq,
  input wire logic [15:0] safeIn,
  output logic [15:0] safeOut,
  output logic linkInData
);
  logic rspValid_q, rspValid_d;
  logic [2:0] rspCmd_q, rspCmd_d;
  logic [15:0] rspData_q, rspData_d;
  logic [3:0] rspCode_q, rspCode_d;
  logic [15:0] sessId_q, sessId_d;
  logic [15:0] safeOut_q, safeOut_d;
  logic inData_q, inData_d;

  always_comb
  begin
    rspValid_d = 1'b0;
    rspCmd_d = rspCmd_q;
    rspData_d = rspData_q;
    rspCode_d = rspCode_q;
    sessId_d = sessId_q + 16'h0001;
    safeOut_d = safeOut_q;
    inData_d = inData_q;
    if (link.mstValid)
    begin
      rspValid_d = 1'b1;
      rspCmd_d = link.mstCmd;
      rspData_d = link.mstData;
      rspCode_d = `SLK_DC_NONE;
      if (!started)
      begin
        rspCmd_d = SLK_CMD_RESET;
        rspCode_d = `SLK_DC_NOT_STARTED;
        inData_d = 1'b0;
      end
      else if (link.mstChk !=
               slk_chk(link.mstCmd, link.mstAddr, link.mstData))
      begin
        rspCmd_d = SLK_CMD_RESET;
        rspCode_d = `SLK_DC_BAD_CRC;
        inData_d = 1'b0;
      end
      else if (link.mstAddr != NODE_ADDR)
      begin
        rspCmd_d = SLK_CMD_RESET;
        rspCode_d = `SLK_DC_INV_ADDR;
        inData_d = 1'b0;
      end
      else if (shutdownReq && link.mstCmd != SLK_CMD_RESET)
      begin
        rspCmd_d = SLK_CMD_SHUTDOWN;
        inData_d = 1'b0;
      end
      else
      begin
        case (link.mstCmd)
          SLK_CMD_RESET: inData_d = 1'b0;
          // Own session id answers the master's
          SLK_CMD_SESSION: rspData_d = sessId_q | 16'h0001;
          SLK_CMD_CONN: rspData_d = link.mstData;
          SLK_CMD_PARAM:
          begin
            if (link.mstData[15:8] != COMM_PRM_LEN)
            begin
              rspCmd_d = SLK_CMD_RESET;
              rspCode_d = `SLK_DC_COMPRM_LEN;
            end
            else if (link.mstData[7:0] != USER_PRM_LEN)
            begin
              rspCmd_d = SLK_CMD_RESET;
              rspCode_d = `SLK_DC_USRPRM_LEN;
            end
          end
          SLK_CMD_DATA:
          begin
            safeOut_d = link.mstData;
            rspData_d = safeIn;
            inData_d = 1'b1;
          end
          default:
          begin
            rspCmd_d = SLK_CMD_RESET;
            rspCode_d = `SLK_DC_UNK_CMD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rspValid_q <= 1'b0;
      rspCmd_q <= SLK_CMD_NONE;
      rspData_q <= 16'h0000;
      rspCode_q <= 4'h0;
      sessId_q <= 16'h0001;
      safeOut_q <= 16'h0000;
      inData_q <= 1'b0;
    end
    else
    begin
      rspValid_q <= rspValid_d;
      rspCmd_q <= rspCmd_d;
      rspData_q <= rspData_d;
      rspCode_q <= rspCode_d;
      sessId_q <= sessId_d;
      safeOut_q <= safeOut_d;
      inData_q <= inData_d;
    end
  end

  assign link.slvValid = rspValid_q;
  assign link.slvCmd = rspCmd_q;
  assign link.slvAddr = NODE_ADDR;
  assign link.slvData = rspData_q;
  assign link.slvChk = slk_chk(rspCmd_q, NODE_ADDR, rspData_q);
  assign link.slvCode = rspCode_q;
  assign link.slvErr = !started || moduleFault;
  assign link.slvFailsafe = failsafeActive || !inData_q;
  assign link.slvModFault = moduleFault;
  assign safeOut = safeOut_q;
  assign linkInData = inData_q;
endmodule : slk_slave

// [tb/slk_link_sva.sv]
// Link protocol checker placed beside the master/slave interface
module slk_link_sva #(
  parameter logic [7:0] SLAVE_ADDR = 8'h01,
  parameter logic [7:0] NODE_ADDR = 8'h01,
  parameter logic [15:0] CONN_ID = 16'h0001
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mstValid,
  input wire logic [2:0] mstCmd,
  input wire logic [7:0] mstAddr,
  input wire logic [15:0] mstData,
  input wire logic [7:0] mstChk,
  input wire logic slvValid,
  input wire logic [2:0] slvCmd,
  input wire logic [7:0] slvAddr,
  input wire logic [15:0] slvData,
  input wire logic [7:0] slvChk,
  input wire logic [3:0] slvCode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_answer_next: assert property (mstValid |=> slvValid)
    else $error("slave answer missing");
  a_no_unsolicited: assert property (slvValid |-> $past(mstValid))
    else $error("slave answered without frame");
  a_valid_pulse: assert property (mstValid |=> !mstValid)
    else $error("master strobe longer than one cycle");
  a_mst_check: assert property (mstValid |->
    mstChk == (mstData[15:8] ^ mstData[7:0] ^ mstAddr ^ {5'h00, mstCmd}))
    else $error("master check byte wrong");
  a_slv_check: assert property (slvValid |->
    slvChk == (slvData[15:8] ^ slvData[7:0] ^ slvAddr ^ {5'h00, slvCmd}))
    else $error("slave check byte wrong");
  a_node_addr: assert property (mstValid |->
    mstAddr == SLAVE_ADDR ##1 slvAddr == NODE_ADDR)
    else $error("frame address wrong");
  // Master launches the next frame in the cycle after taking an answer
  a_session_next: assert property (slvValid && slvCmd == 3'h1 &&
    slvCode == 4'h0 |-> ##1 mstValid && mstCmd == 3'h2)
    else $error("no session frame after reset answer");
  a_conn_next: assert property (slvValid && slvCmd == 3'h2 &&
    slvData != 16'h0000 |-> ##1 mstValid && mstCmd == 3'h3)
    else $error("no connection frame after session answer");
  a_param_next: assert property (slvValid && slvCmd == 3'h3 &&
    slvData == CONN_ID |-> ##1 mstValid && mstCmd == 3'h4)
    else $error("no parameter frame after connection answer");
  a_data_next: assert property (slvValid && slvCmd == 3'h4 |->
    ##1 mstValid && mstCmd == 3'h5)
    else $error("no data frame after parameter answer");

  c_data: cover property (mstValid && mstCmd == 3'h5);
  c_fault: cover property (slvValid && slvCmd == 3'h1 && slvCode != 4'h0);
  c_shut: cover property (slvValid && slvCmd == 3'h6);
endmodule : slk_link_sva

// [tb/tb_top.sv]
// Testbench joining both link ends and driving the register port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys;
  logic rst_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic irq;
  logic started;
  logic moduleFault;
  logic failsafeActive;
  logic shutdownReq;
  logic [15:0] safeIn;
  logic [15:0] safeOut;
  logic linkInData;
  int errTotal = 0;
  int cmpCount = 0;

  slk_link_if link();
  slk_master #(.WD_CYCLES(20)) u_slk_master (.clk_sys(clk_sys),
    .rst_n(rst_n), .link(link), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
  slk_slave u_slk_slave (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .started(started), .moduleFault(moduleFault),
    .failsafeActive(failsafeActive), .shutdownReq(shutdownReq),
    .safeIn(safeIn), .safeOut(safeOut), .linkInData(linkInData));
  slk_link_sva u_slk_link_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .mstValid(link.mstValid), .mstCmd(link.mstCmd), .mstAddr(link.mstAddr),
    .mstData(link.mstData), .mstChk(link.mstChk), .slvValid(link.slvValid),
    .slvCmd(link.slvCmd), .slvAddr(link.slvAddr), .slvData(link.slvData),
    .slvChk(link.slvChk), .slvCode(link.slvCode));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  // Clear stale events first, so only the coming one raises the line
  task automatic arm(input logic [31:0] m);
    logic [31:0] d;
    rd(8'h08, d);
    wr(8'h0c, m);
  endtask : arm

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check({31'h0, irq}, 32'h1);
  endtask : wait_irq

  task automatic settle;
    wait_irq();
    repeat (10) @(posedge clk_sys);
  endtask : settle

  task automatic t_reset_vals;
    logic [31:0] d;
    rd(8'h04, d);
    check(d, 32'h00004064);
    check({31'h0, irq}, 32'h0);
    rd(8'h40, d);
    check(d, 32'h0);
  endtask : t_reset_vals

  task automatic t_not_started;
    logic [31:0] d;
    arm(32'h1);
    wr(8'h00, 32'h1);
    wait_irq();
    rd(8'h04, d);
    check({24'h0, d[15:8] & 8'h5f}, 32'h5f);
    check({31'h0, linkInData}, 32'h0);
  endtask : t_not_started

  task automatic t_bring_up;
    logic [31:0] d;
    arm(32'h2);
    @(posedge clk_sys);
    started <= 1'b1;
    settle();
    rd(8'h04, d);
    check(d, 32'h00000068);
    check({31'h0, linkInData}, 32'h1);
    rd(8'h08, d);
    check({31'h0, d[1]}, 32'h1);
    @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h0);
  endtask : t_bring_up

  task automatic t_mapping;
    logic [31:0] d;
    @(posedge clk_sys);
    safeIn <= 16'ha5c3;
    wr(8'h10, 32'h1234);
    wr(8'h00, 32'h3c1);
    repeat (12) @(posedge clk_sys);
    check({16'h0, safeOut}, 32'h1234);
    rd(8'h18, d);
    check(d, 32'h1234a5c3);
    rd(8'h14, d);
    check(d, 32'h00000068);
    @(posedge clk_sys);
    failsafeActive <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(8'h14, d);
    check(d, 32'h00002068);
    failsafeActive <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : t_mapping

  // Link-fault option, then output slave with error acknowledge
  task automatic t_mod_fault;
    logic [31:0] d;
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, (i == 0) ? 32'h9 : 32'h31);
      arm(32'h1);
      moduleFault <= 1'b1;
      wait_irq();
      rd(8'h04, d);
      @(posedge clk_sys);
      moduleFault <= 1'b0;
      check({24'h0, d[15:8] & 8'h8f}, (i == 0) ? 32'h8d : 32'h8e);
      arm(32'h2);
      settle();
    end
    rd(8'h04, d);
    check(d, 32'h00000068);
  endtask : t_mod_fault

  task automatic t_mst_reset;
    logic [31:0] d;
    arm(32'h1);
    wr(8'h00, 32'h5);
    wait_irq();
    rd(8'h04, d);
    check({24'h0, d[15:8] & 8'h8f}, 32'h8c);
    arm(32'h2);
    rd(8'h00, d);
    check(d, 32'h1);
    settle();
  endtask : t_mst_reset

  task automatic t_deact;
    logic [31:0] d;
    arm(32'h4);
    wr(8'h00, 32'h3);
    wait_irq();
    rd(8'h04, d);
    check({24'h0, d[7:0]}, 32'h6a);
    arm(32'h2);
    wr(8'h00, 32'h1);
    settle();
  endtask : t_deact

  task automatic t_shutdown;
    logic [31:0] d;
    arm(32'h4);
    shutdownReq <= 1'b1;
    wait_irq();
    rd(8'h04, d);
    check({24'h0, d[7:0]}, 32'h69);
    @(posedge clk_sys);
    shutdownReq <= 1'b0;
  endtask : t_shutdown

  task automatic summarize;
    $display("errors=%0d compares=%0d", errTotal, cmpCount);
    if (errTotal == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Whole sequence needs a few hundred cycles; 2 ms is ample
  initial
  begin
    #2ms;
    errTotal++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    started = 1'b0;
    moduleFault = 1'b0;
    failsafeActive = 1'b0;
    shutdownReq = 1'b0;
    safeIn = 16'h0000;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_vals();
    t_not_started();
    t_bring_up();
    t_mapping();
    t_mod_fault();
    t_mst_reset();
    t_deact();
    t_shutdown();
    summarize();
  end
endmodule : tb_top
